// ===== rtl/phpm_top.v
// Summary of operation
// (R1) Port A handshake: line3 ready/avail, line2 acknowledge
// (R2) Port B handshake: line1 ready/avail, line0 acknowledge
// (R3) Three-wire input: line3 ready, line0 accepted
// (R4) Three-wire output: line3 available, line0 ready in
// (R5) Bidirectional: line0 is the direction input
// (R6) Both handshake ports only without request/wait
// (R7) Deskew delay offered on every output port
// (R8) Strobed: transfer on acknowledge falling edge
// (R9) Three-wire: rising edges signal ready and accepted
// (R10) Three-wire on one port, never bidirectional
// (R11) Pulsed input: timer stretches acknowledge
// (R12) Pulsed output: timer drives data-available
// (R13) Request/wait on one port, other is bit
// (R14) Two-bytes option delays request assertion
// (R15) Special request follows idle register by direction
// (R16) Per-bit one/zero/edges/any spec with mask
// (R17) All-bits or any-bit match rule
// (R18) Patterns apply before inversion of inputs; the code matches the inverted inputs
// (R19) Bit port matcher uses catcher output
// (R20) Interrupt on match entry; priority mode continuous
// (R21) Latch-on-match captures inputs until pending clears
// (R22) Match while pending is error, handled by option
// (R23) Interlocked waits for ready or withdrawal
// (R24) Deskew wait is time constant plus one
`timescale 1ns/100ps
`include "phpm_regs.vh"
module phpm_top (
  clk,
  nrst,
  port_cfg,
  hs_type,
  rw_func,
  intr_two_bytes,
  deskew_en,
  deskew_tc,
  pulse_tc,
  cpu_wr,
  cpu_wdata,
  cpu_rd,
  port_pins,
  invert,
  catcher_en,
  catcher_clr,
  pat_spec,
  pat_mask,
  pat_mode,
  latch_on_match,
  intr_on_error,
  clear_pending,
  aux_in,
  aux_out,
  aux_oe,
  cpu_rdata,
  rx_full,
  tx_empty,
  interrupt_pending,
  error_flag,
  match_flag,
  latched_data,
  cfg_error
);
  input  wire        clk;
  input  wire        nrst;
  input  wire [2:0]  port_cfg;        // Active handshake configuration
  input  wire [1:0]  hs_type;         // Handshake type
  input  wire [2:0]  rw_func;         // Request/wait function
  input  wire        intr_two_bytes;
  input  wire        deskew_en;
  input  wire [3:0]  deskew_tc;
  input  wire [7:0]  pulse_tc;        // Linked timer length
  input  wire        cpu_wr;          // Output-direction write pulse
  input  wire [7:0]  cpu_wdata;
  input  wire        cpu_rd;          // Input-direction read pulse
  input  wire [7:0]  port_pins;       // Bit port pins
  input  wire [7:0]  invert;
  input  wire [7:0]  catcher_en;
  input  wire [7:0]  catcher_clr;
  input  wire [23:0] pat_spec;
  input  wire [7:0]  pat_mask;
  input  wire [1:0]  pat_mode;
  input  wire        latch_on_match;
  input  wire        intr_on_error;
  input  wire        clear_pending;
  input  wire [3:0]  aux_in;
  output reg  [3:0]  aux_out;
  output reg  [3:0]  aux_oe;
  output reg  [7:0]  cpu_rdata;
  output reg         rx_full;
  output reg         tx_empty;
  output reg         interrupt_pending;
  output reg         error_flag;
  output reg         match_flag;
  output reg  [7:0]  latched_data;
  output reg         cfg_error;

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [3:0] aux_s;
  wire [7:0] pin_s;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_aux
      phpm_sync u_s (.clk(clk), .nrst(nrst), .pin(aux_in[g]), .level(aux_s[g]));
    end
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      phpm_sync u_s (.clk(clk), .nrst(nrst), .pin(port_pins[g]), .level(pin_s[g]));
    end
  endgenerate

  // ****************************************
  // Line assignment decode
  // ****************************************
  reg ack_raw;
  reg dir_in;       // Bidir direction, high = output
  reg is_out;
  reg rfd_in;       // Three-wire output ready input
  always @* begin
    ack_raw = 1'b1;
    dir_in  = 1'b0;
    rfd_in  = 1'b0;
    is_out  = 1'b0;
    case (port_cfg)
      // (R1) port A lines
      `PHPM_CFG_IO_A:   ack_raw = aux_s[2];
      // (R2) port B lines
      `PHPM_CFG_IO_B:   ack_raw = aux_s[0];
      // (R3) three-wire input
      `PHPM_CFG_3W_IN:  ack_raw = aux_s[2];
      // (R4) three-wire output
      `PHPM_CFG_3W_OUT: begin
        ack_raw = aux_s[2];
        rfd_in  = aux_s[0];
      end
      // (R5) direction from line 0
      `PHPM_CFG_BIDIR: begin
        ack_raw = aux_s[2];
        dir_in  = aux_s[0];
      end
      default: ack_raw = 1'b1;
    endcase
    is_out = (port_cfg == `PHPM_CFG_3W_OUT) || dir_in ||
             ((port_cfg != `PHPM_CFG_3W_IN) && (port_cfg != `PHPM_CFG_BIDIR) &&
              (port_cfg != `PHPM_CFG_BIT) && hs_type[0] && 1'b0);
  end

  // Output direction for single ports is selected by bit 1 of rw_func
  wire single_out = (port_cfg == `PHPM_CFG_IO_A || port_cfg == `PHPM_CFG_IO_B) && rw_func[1];
  wire out_dir    = is_out || single_out;

  // ****************************************
  // Configuration checks
  // ****************************************
  // (R6) (R10) (R13) illegal combinations flagged
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_error <= 1'b0;
    end else begin
      cfg_error <= ((hs_type == `PHPM_HS_3WIRE) &&
                    (port_cfg == `PHPM_CFG_BIDIR)) ||
                   ((hs_type == `PHPM_HS_PULSE) && (port_cfg == `PHPM_CFG_BIDIR)) ||
                   ((rw_func == `PHPM_RW_SPECIAL) && (port_cfg != `PHPM_CFG_BIDIR));
    end
  end

  // ****************************************
  // Acknowledge path with pulsed timer
  // ****************************************
  reg       ack_q;
  reg [7:0] ptim_q;
  wire      ack_fall = ack_q & ~ack_raw;
  wire      pulsed   = (hs_type == `PHPM_HS_PULSE);
  // (R11) acknowledge stretched by timer
  wire      ack_eff  = (pulsed && !out_dir) ? (ptim_q == 8'h00) : ack_raw;
  reg       ack_eff_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q     <= 1'b1;
      ack_eff_q <= 1'b1;
    end else begin
      ack_q     <= ack_raw;
      ack_eff_q <= ack_eff;
    end
  end
  wire ack_eff_fall = ack_eff_q & ~ack_eff;
  wire ack_eff_rise = ~ack_eff_q & ack_eff;

  // Matcher input and match edge, used by the latch logic below
  reg  [7:0] catch_q;
  // (R18) (R19) matcher input: polarity then catcher
  wire [7:0] pol   = pin_s ^ invert;
  wire [7:0] mdata = (catcher_en & catch_q) | (~catcher_en & pol);
  wire       match;
  reg        match_q;
  reg        err_pend_q;
  wire       match_rise = match & ~match_q;

  // ****************************************
  // Double buffer and handshake
  // ****************************************
  reg [7:0] buf_q;
  reg       buf_full_q;
  reg       dav_int_q;     // Internal data-available, active low
  reg       rdy_q;         // Ready-for-data level
  reg [3:0] dsk_q;
  reg       dav_int_d1_q;
  wire      dsk_done = (dsk_q == 4'h0) || !deskew_en;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_q        <= 8'h00;
      buf_full_q   <= 1'b0;
      dav_int_q    <= 1'b1;
      rdy_q        <= 1'b1;
      dsk_q        <= 4'h0;
      rx_full      <= 1'b0;
      tx_empty     <= 1'b1;
      latched_data <= 8'h00;
      dav_int_d1_q <= 1'b1;
    end else begin
      dav_int_d1_q <= dav_int_q;
      if (dsk_q != 4'h0) begin
        dsk_q <= dsk_q - 4'h1;
      end
      if (out_dir) begin
        if (cpu_wr && tx_empty) begin
          tx_empty <= 1'b0;
          buf_q    <= cpu_wdata;
        end
        if (!tx_empty && !buf_full_q && dav_int_q) begin
          buf_full_q <= 1'b1;
          tx_empty   <= 1'b1;
          // (R24) deskew loaded as data enters buffer; tc+1 cycles
          dsk_q      <= deskew_tc;
        end
        // (R23) (R7) wait for ready and deskew
        if (buf_full_q && dav_int_q && dsk_done &&
            ((port_cfg == `PHPM_CFG_3W_OUT) ? rfd_in : ack_eff)) begin
          dav_int_q <= 1'b0;
        end
        // (R8) (R9) strobe or acceptance finishes transfer
        if (!dav_int_q && ((hs_type == `PHPM_HS_STROBE) ? ack_fall : ack_eff_rise)) begin
          dav_int_q  <= 1'b1;
          buf_full_q <= 1'b0;
        end
      end else begin
        if (cpu_rd && rx_full) begin
          rx_full <= 1'b0;
        end
        // (R8) strobed capture on acknowledge fall
        if (ack_eff_fall && rdy_q && !buf_full_q) begin
          buf_q      <= pin_s;
          buf_full_q <= 1'b1;
          rdy_q      <= (hs_type == `PHPM_HS_STROBE);
        end
        if (buf_full_q && !rx_full && !cpu_rd) begin
          latched_data <= buf_q;
          rx_full      <= 1'b1;
          buf_full_q   <= 1'b0;
        end
        // (R23) ready only after source withdraws
        if (!rdy_q && ack_eff && !buf_full_q) begin
          rdy_q <= 1'b1;
        end
      end
      // (R21) capture on interrupt when latching
      if (!out_dir && latch_on_match && match_rise && !interrupt_pending) begin
        latched_data <= mdata;
      end else if (!out_dir && !latch_on_match && port_cfg == `PHPM_CFG_BIT) begin
        latched_data <= mdata;
      end
    end
  end

  // (R12) pulsed output timer on data-available fall
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptim_q <= 8'h00;
    end else if (pulsed && (out_dir ? (dav_int_d1_q & ~dav_int_q) : ack_fall)) begin
      ptim_q <= pulse_tc;
    end else if (ptim_q != 8'h00) begin
      ptim_q <= ptim_q - 8'h01;
    end
  end
  wire dav_line = (pulsed && out_dir) ? (ptim_q == 8'h00) : dav_int_q;

  // ****************************************
  // Request line
  // ****************************************
  reg req;
  always @* begin
    req = 1'b0;
    if (rw_func == `PHPM_RW_SPECIAL) begin
      // (R15) idle register status
      req = dir_in ? tx_empty : rx_full;
    end else if (rw_func == `PHPM_RW_REQ) begin
      // (R14) two-byte option
      if (out_dir) begin
        req = intr_two_bytes ? (tx_empty && !buf_full_q) : tx_empty;
      end else begin
        req = intr_two_bytes ? (rx_full && buf_full_q) : rx_full;
      end
    end
  end

  // ****************************************
  // Auxiliary outputs
  // ****************************************
  wire rdy_line = rdy_q && !buf_full_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aux_out <= 4'h0;
      aux_oe  <= 4'h0;
    end else begin
      case (port_cfg)
        `PHPM_CFG_IO_A, `PHPM_CFG_BIDIR: begin
          aux_out <= {out_dir ? dav_line : rdy_line, 1'b0, req, 1'b0};
          aux_oe  <= {1'b1, 1'b0, rw_func[2], 1'b0};
        end
        `PHPM_CFG_IO_B: begin
          aux_out <= {req, 1'b0, out_dir ? dav_line : rdy_line, 1'b0};
          aux_oe  <= {rw_func[2], 1'b0, 1'b1, 1'b0};
        end
        // (R9) open-drain ready and accepted
        `PHPM_CFG_3W_IN: begin
          aux_out <= {1'b0, 1'b0, req, 1'b0};
          aux_oe  <= {~rdy_line, 1'b0, rw_func[2], ~rx_full};
        end
        `PHPM_CFG_3W_OUT: begin
          aux_out <= {dav_line, 1'b0, req, 1'b0};
          aux_oe  <= {1'b1, 1'b0, rw_func[2], 1'b0};
        end
        default: begin
          aux_out <= 4'h0;
          aux_oe  <= 4'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Pattern recognition
  // ****************************************
  phpm_match u_match (
    .clk     (clk),
    .nrst    (nrst),
    .data_in (mdata),
    .spec    (pat_spec),
    .mask    (pat_mask),
    .mode    (pat_mode),
    .match   (match)
  );

  // Ones catchers and interrupt bookkeeping
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      catch_q           <= 8'h00;
      match_q           <= 1'b0;
      interrupt_pending <= 1'b0;
      error_flag        <= 1'b0;
      err_pend_q        <= 1'b0;
      match_flag        <= 1'b0;
      cpu_rdata         <= 8'h00;
    end else begin
      catch_q    <= (catch_q & ~catcher_clr) | (pol & catcher_en);
      match_q    <= match;
      match_flag <= match;
      cpu_rdata  <= latched_data;
      if (clear_pending && !(pat_mode == `PHPM_MM_ORPRI && match)) begin
        interrupt_pending <= 1'b0;
        error_flag        <= 1'b0;
        // (R22) deferred error re-raises pending
        if (err_pend_q) begin
          interrupt_pending <= 1'b1;
          error_flag        <= 1'b1;
          err_pend_q        <= 1'b0;
        end
      end
      // (R20) entry or continuous in priority mode
      if ((pat_mode == `PHPM_MM_ORPRI) ? match : match_rise) begin
        // A match in the cycle of a clear sets pending again
        if (!interrupt_pending || clear_pending) begin
          interrupt_pending <= 1'b1;
        end else if (intr_on_error && !error_flag && pat_mode != `PHPM_MM_ORPRI) begin
          // (R22) remember error
          err_pend_q <= 1'b1;
        end
      end
    end
  end
endmodule // phpm_top

// ===== rtl/phpm_regs.vh
`ifndef PHPM_REGS_VH
`define PHPM_REGS_VH
// ****************************************
// Port configuration codes
// ****************************************
`define PHPM_CFG_BIT      3'h0
`define PHPM_CFG_IO_A     3'h1
`define PHPM_CFG_IO_B     3'h2
`define PHPM_CFG_3W_IN    3'h3
`define PHPM_CFG_3W_OUT   3'h4
`define PHPM_CFG_BIDIR    3'h5
// ****************************************
// Handshake types
// ****************************************
`define PHPM_HS_INTLK     2'h0
`define PHPM_HS_STROBE    2'h1
`define PHPM_HS_PULSE     2'h2
`define PHPM_HS_3WIRE     2'h3
// ****************************************
// Request/wait function codes
// ****************************************
`define PHPM_RW_OFF       3'h0
`define PHPM_RW_REQ       3'h4
`define PHPM_RW_SPECIAL   3'h5
// ****************************************
// Pattern bit specs and match modes
// ****************************************
`define PHPM_PB_ZERO      3'h0
`define PHPM_PB_ONE       3'h1
`define PHPM_PB_RISE      3'h2
`define PHPM_PB_FALL      3'h3
`define PHPM_PB_ANY       3'h4
`define PHPM_MM_AND       2'h0
`define PHPM_MM_OR        2'h1
`define PHPM_MM_ORPRI     2'h2
// ****************************************
// Widths and timing
// ****************************************
`define PHPM_DESKEW_W     4
`define PHPM_PULSE_W      8
`define PHPM_SYNC_STAGES  3
`endif

// ===== rtl/phpm_sync.v
`timescale 1ns/100ps
// Three-stage pin synchroniser; a change counts when stages two and three agree
module phpm_sync (
  clk,
  nrst,
  pin,
  level
);
  input  wire clk;
  input  wire nrst;
  input  wire pin;
  output reg  level;

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Shift chain and agreement filter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule // phpm_sync

// ===== rtl/phpm_match.v
`timescale 1ns/100ps
`include "phpm_regs.vh"
// Pattern matcher for one 8-bit port
module phpm_match (
  clk,
  nrst,
  data_in,
  spec,
  mask,
  mode,
  match
);
  input  wire        clk;
  input  wire        nrst;
  input  wire [7:0]  data_in;
  input  wire [23:0] spec;
  input  wire [7:0]  mask;
  input  wire [1:0]  mode;
  output wire        match;

  reg [7:0] prev_q;
  reg [7:0] hit;
  reg [2:0] s;
  integer   i;

  // Previous sample for edge specs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= data_in;
    end
  end

  // (R16) per-bit condition
  always @* begin
    hit = 8'h00;
    s   = 3'h0;
    for (i = 0; i < 8; i = i + 1) begin
      s = spec[i*3 +: 3];
      case (s)
        `PHPM_PB_ZERO: hit[i] = ~data_in[i];
        `PHPM_PB_ONE:  hit[i] = data_in[i];
        `PHPM_PB_RISE: hit[i] = data_in[i] & ~prev_q[i];
        `PHPM_PB_FALL: hit[i] = ~data_in[i] & prev_q[i];
        `PHPM_PB_ANY:  hit[i] = data_in[i] ^ prev_q[i];
        default:       hit[i] = 1'b0;
      endcase
    end
  end

  // (R17) all-bits or any-bit
  assign match = (mode == `PHPM_MM_AND) ? ((|mask) && ((hit & mask) == mask))
                                        : (|(hit & mask));
endmodule // phpm_match

// ===== sim/phpm_chk.sv
`timescale 1ns/100ps
module phpm_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [2:0] port_cfg,
  input wire logic [1:0] hs_type,
  input wire logic       deskew_en,
  input wire logic [3:0] deskew_tc,
  input wire logic [3:0] aux_out,
  input wire logic [3:0] aux_oe,
  input wire logic       tx_empty,
  input wire logic       interrupt_pending,
  input wire logic       error_flag,
  input wire logic       cfg_error
);
  reg [1:0] up_q;
  reg [4:0] dsk_q;
  reg       te_q;
  wire      ok = (up_q == 2'h3);
  // ****************************************
  // Settle and deskew counters
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up_q  <= 2'h0;
      dsk_q <= 5'h1F;
      te_q  <= 1'b1;
    end else begin
      te_q <= tx_empty;
      if (up_q != 2'h3)
        up_q <= up_q + 2'h1;
      if (tx_empty && !te_q)
        dsk_q <= 5'h0;
      else if (dsk_q != 5'h1F)
        dsk_q <= dsk_q + 5'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_line_a; ok && $stable(port_cfg) && port_cfg == 3'h1 |-> aux_oe[3] && !aux_oe[2];
  endproperty
  property p_line_b; ok && $stable(port_cfg) && port_cfg == 3'h2 |-> aux_oe[1] && !aux_oe[0];
  endproperty
  property p_tw_in; ok && $stable(port_cfg) && port_cfg == 3'h3 |-> !aux_out[3] && !aux_oe[2] && !aux_out[0];
  endproperty
  property p_tw_out; ok && $stable(port_cfg) && port_cfg == 3'h4 |-> aux_oe[3] && aux_oe[2:0] == 3'h0 ||
    aux_oe[3] && !aux_oe[2] && !aux_oe[0];
  endproperty
  property p_bidir; ok && $stable(port_cfg) && port_cfg == 3'h5 |-> aux_oe[3] && !aux_oe[2] && !aux_oe[0];
  endproperty
  property p_no3w; ok && $stable(port_cfg) && $stable(hs_type) && port_cfg == 3'h5 && hs_type == 2'h3 |-> cfg_error;
  endproperty
  property p_nopulse; ok && $stable(port_cfg) && $stable(hs_type) && port_cfg == 3'h5 && hs_type == 2'h2 |-> cfg_error;
  endproperty
  property p_err; error_flag |-> interrupt_pending;
  endproperty
  property p_dsk; ok && deskew_en && port_cfg == 3'h1 && $fell(aux_out[3]) |-> dsk_q >= {1'b0, deskew_tc} + 5'h1;
  endproperty
  a_line_a: assert property (p_line_a) else $error("port A lines wrong");
  a_line_b: assert property (p_line_b) else $error("port B lines wrong");
  a_tw_in: assert property (p_tw_in) else $error("three-wire in lines wrong");
  a_tw_out: assert property (p_tw_out) else $error("three-wire out lines wrong");
  a_bidir: assert property (p_bidir) else $error("bidir lines wrong");
  a_no3w: assert property (p_no3w) else $error("three-wire bidir accepted");
  a_nopulse: assert property (p_nopulse) else $error("pulsed bidir accepted");
  a_err: assert property (p_err) else $error("error without pending");
  a_dsk: assert property (p_dsk) else $error("deskew too short");
  c_err: cover property (interrupt_pending && error_flag);
  c_dav: cover property ($fell(aux_out[3]));
  c_cfg: cover property (cfg_error);
endmodule  // phpm_chk
bind phpm_top phpm_chk u_phpm_chk (.clk(clk), .nrst(nrst), .port_cfg(port_cfg), .hs_type(hs_type),
  .deskew_en(deskew_en), .deskew_tc(deskew_tc), .aux_out(aux_out), .aux_oe(aux_oe),
  .tx_empty(tx_empty), .interrupt_pending(interrupt_pending), .error_flag(error_flag),
  .cfg_error(cfg_error));

// ===== sim/phpm_peer.sv
`timescale 1ns/100ps
// Interlocked receiver on the far side of an output port
module phpm_peer (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic dav_n,
  input  wire logic slow,
  output reg        ack_n
);
  reg [4:0] cnt_q;
  reg       armed_q;     // Data-available seen high since last accept
  // ****************************************
  // Acknowledge and ready again
  // ****************************************
  // accept then ready
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_n   <= 1'b1;
      cnt_q   <= 5'h0;
      armed_q <= 1'b0;
    end else if (ack_n) begin
      cnt_q <= 5'h0;
      if (dav_n)
        armed_q <= 1'b1;
      if (!dav_n && armed_q) begin
        ack_n   <= 1'b0;
        armed_q <= 1'b0;
      end
    end else begin
      cnt_q <= cnt_q + 5'h1;
      if (cnt_q == (slow ? 5'h14 : 5'h2))
        ack_n <= 1'b1;
    end
  end
endmodule  // phpm_peer

// ===== sim/phpm_top_tb.sv
`timescale 1ns/100ps
module phpm_top_tb;
  reg         clk, nrst, intr_two_bytes, deskew_en, cpu_wr, cpu_rd, latch_on_match;
  reg         intr_on_error, clear_pending, dir, slow;
  reg  [2:0]  port_cfg, rw_func;
  reg  [1:0]  hs_type, pat_mode;
  reg  [3:0]  deskew_tc;
  reg  [7:0]  pulse_tc, cpu_wdata, port_pins, invert, catcher_en, catcher_clr, pat_mask;
  reg  [23:0] pat_spec;
  wire [3:0]  aux_in, aux_out, aux_oe;
  wire [7:0]  cpu_rdata, latched_data;
  wire        rx_full, tx_empty, interrupt_pending, error_flag, match_flag, cfg_error, ack_n;
  integer     fail_count, n_checks, n, k;
  assign aux_in = {aux_oe[3] ? aux_out[3] : 1'b1, ack_n, aux_oe[1] ? aux_out[1] : 1'b1,
                   aux_oe[0] ? aux_out[0] : dir};
  phpm_top u_phpm_top (.clk(clk), .nrst(nrst), .port_cfg(port_cfg), .hs_type(hs_type),
    .rw_func(rw_func), .intr_two_bytes(intr_two_bytes), .deskew_en(deskew_en),
    .deskew_tc(deskew_tc), .pulse_tc(pulse_tc), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
    .cpu_rd(cpu_rd), .port_pins(port_pins), .invert(invert), .catcher_en(catcher_en),
    .catcher_clr(catcher_clr), .pat_spec(pat_spec), .pat_mask(pat_mask), .pat_mode(pat_mode),
    .latch_on_match(latch_on_match), .intr_on_error(intr_on_error),
    .clear_pending(clear_pending), .aux_in(aux_in), .aux_out(aux_out), .aux_oe(aux_oe),
    .cpu_rdata(cpu_rdata), .rx_full(rx_full), .tx_empty(tx_empty),
    .interrupt_pending(interrupt_pending), .error_flag(error_flag), .match_flag(match_flag),
    .latched_data(latched_data), .cfg_error(cfg_error));
  phpm_peer u_phpm_peer (.clk(clk), .nrst(nrst), .dav_n(aux_out[3]), .slow(slow), .ack_n(ack_n));
  // ****************************************
  // Clock, helpers and report
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task tk(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input [8*12-1:0] what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %0t: %0s", $time, what);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wdav(input logic v);
    n = 0;
    while (aux_out[3] !== v && n < 100) begin
      tk(1);
      n = n + 1;
    end
    if (n == 100) begin
      chk(1'b0, 1'b1, "dav timeout");
      stop_test;
    end
  endtask
  task wpend;
    n = 0;
    while (interrupt_pending !== 1'b1 && n < 30) begin
      tk(1);
      n = n + 1;
    end
    chk(interrupt_pending, 1'b1, "no pending");
  endtask
  task clr;
    clear_pending = 1'b1;
    tk(1);
    clear_pending = 1'b0;
    tk(2);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_out;
    port_cfg = 3'h1;
    rw_func = 3'h2;
    deskew_en = 1'b1;
    deskew_tc = 4'h5;
    slow = 1'b1;
    tk(6);
    cpu_wr = 1'b1;
    tk(1);
    cpu_wr = 1'b0;
    wdav(1'b0);
    chk(n >= 6, 1'b1, "deskew");
    cpu_wr = 1'b1;
    tk(1);
    cpu_wr = 1'b0;
    wdav(1'b1);
    wdav(1'b0);
    chk(ack_n, 1'b1, "not ready");
    $display("t_out done");
  endtask
  task t_match;
    port_cfg = 3'h0;
    rw_func = 3'h0;
    pat_mask = 8'h03;
    pat_spec = 24'h000001;
    latch_on_match = 1'b1;
    intr_on_error = 1'b1;
    port_pins = 8'h01;
    wpend;
    chk(match_flag, 1'b1, "match flag");
    chk(latched_data, 8'h01, "latch");
    port_pins = 8'h03;
    tk(8);
    port_pins = 8'h81;
    tk(8);
    chk(error_flag, 1'b0, "early error");
    port_pins = 8'h03;
    tk(8);
    chk(latched_data, 8'h01, "latch held");
    clr;
    chk({interrupt_pending, error_flag}, 8'h03, "err reload");
    clr;
    chk({interrupt_pending, error_flag}, 8'h00, "err clear");
    invert = 8'h03;
    port_pins = 8'h02;
    wpend;
    invert = 8'h00;
    tk(8);
    clr;
    $display("t_match done");
  endtask
  task t_codes;
    latch_on_match = 1'b0;
    intr_on_error = 1'b0;
    pat_mode = 2'h1;
    for (k = 0; k < 5; k = k + 1) begin
      pat_spec = 24'h000008 | k;
      port_pins = (k == 0 || k == 3) ? 8'h01 : 8'h00;
      tk(8);
      clr;
      chk(interrupt_pending, 1'b0, "idle");
      port_pins = port_pins ^ 8'h01;
      wpend;
    end
    pat_mode = 2'h2;
    pat_mask = 8'h01;
    pat_spec = 24'h000001;
    tk(8);
    clr;
    chk(interrupt_pending, 1'b1, "prio held");
    port_pins = 8'h00;
    tk(8);
    clr;
    chk(interrupt_pending, 1'b0, "prio clear");
    $display("t_codes done");
  endtask
  task t_cfg;
    for (k = 1; k < 6; k = k + 1) begin
      port_cfg = k;
      hs_type = (k == 3 || k == 4) ? 2'h3 : 2'h0;
      tk(3);
    end
    hs_type = 2'h3;
    tk(3);
    chk(cfg_error, 1'b1, "3w bidir");
    hs_type = 2'h2;
    tk(3);
    chk(cfg_error, 1'b1, "pulse bidir");
    hs_type = 2'h0;
    rw_func = 3'h5;
    dir = 1'b1;
    tk(8);
    chk(aux_out[1], 1'b1, "req out");
    dir = 1'b0;
    tk(8);
    cpu_rd = 1'b1;
    tk(1);
    cpu_rd = 1'b0;
    tk(3);
    chk(aux_out[1], 1'b0, "req in");
    $display("t_cfg done");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, intr_two_bytes, deskew_en, cpu_wr, cpu_rd, latch_on_match} = 6'h00;
    {intr_on_error, clear_pending, dir, slow, hs_type, pat_mode} = 8'h00;
    {port_cfg, rw_func, deskew_tc} = 10'h000;
    {pulse_tc, cpu_wdata, port_pins, invert} = 32'h04A50000;
    {catcher_en, catcher_clr, pat_mask, pat_spec} = 48'h0;
    fail_count = 0;
    n_checks = 0;
    tk(4);
    nrst = 1'b1;
    tk(1);
    chk({tx_empty, interrupt_pending, error_flag, cfg_error}, 8'h08, "reset");
    t_out;
    t_match;
    t_codes;
    t_cfg;
    stop_test;
  end
endmodule  // phpm_top_tb
